// ===== src/rx_cfg_pkg.sv
// Purpose: shared constants for the receiver configuration and sync block
// Assumes: one 8-bit register per aligned 32-bit APB word
// Notes: register indices are kept, byte address is four times the index
package rx_cfg_pkg;
  localparam logic [7:0] idx_poly_cfg = 8'h11;
  localparam logic [7:0] idx_sync_ctl = 8'h12;
  localparam logic [7:0] idx_spare = 8'h13;
  localparam logic [7:0] idx_strength = 8'h14;
  localparam logic [7:0] idx_pattern0 = 8'h16;
  localparam logic [7:0] idx_pattern1 = 8'h17;
  localparam logic [7:0] idx_pattern2 = 8'h18;
  localparam logic [7:0] idx_pattern3 = 8'h19;
  localparam logic [7:0] idx_match_stat = 8'h1f;
  localparam logic [7:0] rst_poly_cfg = 8'h38;
  localparam logic [7:0] rst_sync_ctl = 8'h18;
  localparam logic [7:0] rst_spare = 8'h07;
  localparam logic [7:0] rst_pattern = 8'h00;
  localparam logic [3:0] poly_rsvd_nibble = 4'h8;
  localparam int poly_freq_lsb = 4;
  localparam int sync_filter_bit = 7;
  localparam int sync_bitsync_bit = 6;
  localparam int sync_recog_bit = 5;
  localparam int sync_len_lsb = 3;
  localparam int sync_tol_lsb = 1;
endpackage

// ===== src/pattern_if.sv
`timescale 1ns/1ps
// Purpose: carries the sync detector settings and result
// Assumes: single clock domain
// Notes: none
interface pattern_if;
  logic recog_on;
  logic [1:0] length_sel;
  logic [1:0] tolerance;
  logic [31:0] pattern_value;
  logic match;
  modport ctl (output recog_on, output length_sel, output tolerance, output pattern_value, input match);
  modport det (input recog_on, input length_sel, input tolerance, input pattern_value, output match);
endinterface

// ===== src/pattern_detector.sv
`timescale 1ns/1ps
// Purpose: sliding sync pattern detector with error tolerance
// Assumes: one received bit per bit_valid pulse
// Notes: compares the most significant configured bytes first
module pattern_detector (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bit_valid,
  input wire logic bit_in,
  pattern_if.det pif
);
  logic [31:0] shift_reg;
  logic [31:0] window;
  logic [31:0] diff;
  logic [31:0] len_mask;
  logic [5:0] err_cnt;
  logic [5:0] seen_reg;
  logic [5:0] need;
  logic match_reg;

  // history of received bits, newest in bit 0
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 32'h0;
      seen_reg <= 6'h0;
    end else if (bit_valid) begin
      shift_reg <= {shift_reg[30:0], bit_in};
      if (seen_reg != 6'd32) seen_reg <= seen_reg + 6'd1;
    end
  end

  // length picks the top bytes of the pattern, aligned to newest bits
  // the bit arriving now is part of the compared window
  always_comb begin
    window = {shift_reg[30:0], bit_in};
    case (pif.length_sel)
      2'b00: begin len_mask = 32'h0000_00ff; need = 6'd8; end
      2'b01: begin len_mask = 32'h0000_ffff; need = 6'd16; end
      2'b10: begin len_mask = 32'h00ff_ffff; need = 6'd24; end
      default: begin len_mask = 32'hffff_ffff; need = 6'd32; end
    endcase
    case (pif.length_sel)
      2'b00: diff = (window ^ {24'h0, pif.pattern_value[31:24]}) & len_mask;
      2'b01: diff = (window ^ {16'h0, pif.pattern_value[31:16]}) & len_mask;
      2'b10: diff = (window ^ {8'h0, pif.pattern_value[31:8]}) & len_mask;
      default: diff = window ^ pif.pattern_value;
    endcase
    err_cnt = 6'h0;
    for (int i = 0; i < 32; i++) err_cnt = err_cnt + {5'h0, diff[i]};
  end

  // one-cycle match pulse after a bit completes a tolerated pattern
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) match_reg <= 1'b0;
    else match_reg <= pif.recog_on && bit_valid && (seen_reg >= need - 6'd1)
                      && (err_cnt <= {4'h0, pif.tolerance});
  end
  assign pif.match = match_reg;
endmodule // pattern_detector

// ===== src/rx_sync_rssi_config.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
// Purpose: receiver filter, sync control and signal strength registers on APB
// Assumes: rx bits and strength value synchronous to ref_clk
// Notes: every access completes with pready high in its first access cycle
module rx_sync_rssi_config (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic [7:0] signal_strength_value,
  output logic [3:0] poly_centre_freq_sel,
  output logic poly_filter_on,
  output logic bit_synchronizer_on,
  output logic pattern_match
);
  logic [7:0] poly_cfg_reg;
  logic [7:0] sync_ctl_reg;
  logic [7:0] spare_reg;
  logic [7:0] pattern_reg [4];
  logic match_seen_reg;
  logic [7:0] rd_next;
  logic [9:0] widx;
  logic [7:0] widx_low;
  logic aligned;
  logic in_page;
  logic hit_poly;
  logic hit_sync;
  logic hit_spare;
  logic hit_strength;
  logic hit_pat0;
  logic hit_pat1;
  logic hit_pat2;
  logic hit_pat3;
  logic hit_stat;
  logic mapped;
  logic access;
  logic wr_en;
  logic rd_en;
  logic wr_poly;
  logic wr_sync;
  logic wr_spare;
  logic wr_pat0;
  logic wr_pat1;
  logic wr_pat2;
  logic wr_pat3;
  logic clr_stat;
  pattern_if pif ();

  // word index from byte address; low two bits must be zero
  assign widx = paddr[11:2];
  assign widx_low = widx[7:0];
  assign aligned = (paddr[1:0] == 2'b00);
  assign in_page = (widx[9:8] == 2'b00);

  // access phase strobes
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;

  // one hit line per mapped word
  assign hit_poly = aligned && in_page && (widx_low == rx_cfg_pkg::idx_poly_cfg);
  assign hit_sync = aligned && in_page && (widx_low == rx_cfg_pkg::idx_sync_ctl);
  assign hit_spare = aligned && in_page && (widx_low == rx_cfg_pkg::idx_spare);
  assign hit_strength = aligned && in_page && (widx_low == rx_cfg_pkg::idx_strength);
  assign hit_pat0 = aligned && in_page && (widx_low == rx_cfg_pkg::idx_pattern0);
  assign hit_pat1 = aligned && in_page && (widx_low == rx_cfg_pkg::idx_pattern1);
  assign hit_pat2 = aligned && in_page && (widx_low == rx_cfg_pkg::idx_pattern2);
  assign hit_pat3 = aligned && in_page && (widx_low == rx_cfg_pkg::idx_pattern3);
  assign hit_stat = aligned && in_page && (widx_low == rx_cfg_pkg::idx_match_stat);

  // any mapped word; everything else is refused
  always_comb begin
    mapped = 1'b0;
    if (hit_poly) begin
      mapped = 1'b1;
    end
    if (hit_sync) begin
      mapped = 1'b1;
    end
    if (hit_spare) begin
      mapped = 1'b1;
    end
    if (hit_strength) begin
      mapped = 1'b1;
    end
    if (hit_pat0) begin
      mapped = 1'b1;
    end
    if (hit_pat1) begin
      mapped = 1'b1;
    end
    if (hit_pat2) begin
      mapped = 1'b1;
    end
    if (hit_pat3) begin
      mapped = 1'b1;
    end
    if (hit_stat) begin
      mapped = 1'b1;
    end
  end

  // zero wait state; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // per-register write strobes; strength has none, so writes to it vanish
  assign wr_poly = wr_en && hit_poly;
  assign wr_sync = wr_en && hit_sync;
  assign wr_spare = wr_en && hit_spare;
  assign wr_pat0 = wr_en && hit_pat0;
  assign wr_pat1 = wr_en && hit_pat1;
  assign wr_pat2 = wr_en && hit_pat2;
  assign wr_pat3 = wr_en && hit_pat3;
  assign clr_stat = wr_en && hit_stat && pwdata[0];

  // filter configuration register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      poly_cfg_reg <= rx_cfg_pkg::rst_poly_cfg;
    end else if (wr_poly) begin
      poly_cfg_reg <= pwdata[7:0];
    end
  end

  // sync control register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_ctl_reg <= rx_cfg_pkg::rst_sync_ctl;
    end else if (wr_sync) begin
      sync_ctl_reg <= pwdata[7:0];
    end
  end

  // spare register stores whatever software writes; software keeps the default
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      spare_reg <= rx_cfg_pkg::rst_spare;
    end else if (wr_spare) begin
      spare_reg <= pwdata[7:0];
    end
  end

  // pattern byte 0, the most significant
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_reg[0] <= rx_cfg_pkg::rst_pattern;
    end else if (wr_pat0) begin
      pattern_reg[0] <= pwdata[7:0];
    end
  end

  // pattern byte 1
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_reg[1] <= rx_cfg_pkg::rst_pattern;
    end else if (wr_pat1) begin
      pattern_reg[1] <= pwdata[7:0];
    end
  end

  // pattern byte 2
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_reg[2] <= rx_cfg_pkg::rst_pattern;
    end else if (wr_pat2) begin
      pattern_reg[2] <= pwdata[7:0];
    end
  end

  // pattern byte 3, the least significant
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_reg[3] <= rx_cfg_pkg::rst_pattern;
    end else if (wr_pat3) begin
      pattern_reg[3] <= pwdata[7:0];
    end
  end

  // sticky match flag, cleared by writing bit 0; a new match wins over the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      match_seen_reg <= 1'b0;
    end else if (pif.match) begin
      match_seen_reg <= 1'b1;
    end else if (clr_stat) begin
      match_seen_reg <= 1'b0;
    end
  end

  // read mux; strength is passed live and has no storage
  always_comb begin
    case (widx_low)
      rx_cfg_pkg::idx_poly_cfg: begin
        rd_next = poly_cfg_reg;
      end
      rx_cfg_pkg::idx_sync_ctl: begin
        rd_next = sync_ctl_reg;
      end
      rx_cfg_pkg::idx_spare: begin
        rd_next = spare_reg;
      end
      rx_cfg_pkg::idx_strength: begin
        rd_next = signal_strength_value;
      end
      rx_cfg_pkg::idx_pattern0: begin
        rd_next = pattern_reg[0];
      end
      rx_cfg_pkg::idx_pattern1: begin
        rd_next = pattern_reg[1];
      end
      rx_cfg_pkg::idx_pattern2: begin
        rd_next = pattern_reg[2];
      end
      rx_cfg_pkg::idx_pattern3: begin
        rd_next = pattern_reg[3];
      end
      rx_cfg_pkg::idx_match_stat: begin
        rd_next = {7'h0, match_seen_reg};
      end
      default: begin
        rd_next = 8'h0;
      end
    endcase
  end

  // read data only during a mapped read access, upper bits zero
  always_comb begin
    prdata = 32'h0;
    if (rd_en && mapped) begin
      prdata = {24'h0, rd_next};
    end
  end

  // centre frequency select to the polyphase filter
  assign poly_centre_freq_sel = poly_cfg_reg[rx_cfg_pkg::poly_freq_lsb +: 4];

  // filter and synchronizer enables to the demodulator
  assign poly_filter_on = sync_ctl_reg[rx_cfg_pkg::sync_filter_bit];
  assign bit_synchronizer_on = !sync_ctl_reg[rx_cfg_pkg::sync_bitsync_bit];

  // detector settings
  assign pif.recog_on = sync_ctl_reg[rx_cfg_pkg::sync_recog_bit];
  assign pif.length_sel = sync_ctl_reg[rx_cfg_pkg::sync_len_lsb +: 2];
  assign pif.tolerance = sync_ctl_reg[rx_cfg_pkg::sync_tol_lsb +: 2];

  // pattern word, byte 0 on top so short lengths use the top bytes
  assign pif.pattern_value = {pattern_reg[0], pattern_reg[1], pattern_reg[2], pattern_reg[3]};

  // match pulse straight from the detector flip-flop
  assign pattern_match = pif.match;

  // sliding pattern detector
  pattern_detector u_det (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .pif(pif.det)
  );
endmodule // rx_sync_rssi_config

// ===== verif/rx_cfg_sva.sv
// Purpose: port checks for the receiver config block
// Assumes: zero wait state apb, one clock
// Notes: bound from the testbench file
`timescale 1ns/1ps
module rx_cfg_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic [7:0] signal_strength_value,
  input wire logic [3:0] poly_centre_freq_sel,
  input wire logic poly_filter_on,
  input wire logic bit_synchronizer_on,
  input wire logic pattern_match
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // access and write strobes
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  a_ready_now: assert property (acc |-> pready) else $error("pready low in access");
  a_freq_follow: assert property (wr && paddr == 12'h044 |=>
    poly_centre_freq_sel == $past(pwdata[7:4])) else $error("centre frequency select wrong");
  a_filter_follow: assert property (wr && paddr == 12'h048 |=>
    poly_filter_on == $past(pwdata[7])) else $error("filter enable wrong");
  a_filter_hold: assert property (!(wr && paddr == 12'h048) |=> $stable(poly_filter_on))
    else $error("filter enable moved");
  a_bitsync_follow: assert property (wr && paddr == 12'h048 |=>
    bit_synchronizer_on != $past(pwdata[6])) else $error("synchronizer enable wrong");
  a_strength_live: assert property (acc && !pwrite && paddr == 12'h050 |->
    prdata == {24'h0, signal_strength_value}) else $error("strength read wrong");
  a_match_cause: assert property (pattern_match |-> $past(rx_bit_valid))
    else $error("match without a received bit");
  a_bad_addr: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  a_good_addr: assert property (acc && paddr == 12'h044 |-> !pslverr) else $error("mapped access refused");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  c_ctl_write: cover property (wr && paddr == 12'h048);
  c_match: cover property (pattern_match);
  c_refused: cover property (acc && pslverr);
endmodule // rx_cfg_sva

// ===== verif/bit_source.sv
// Purpose: radio front end model, bit stream and strength value
// Assumes: bits launched just after a rising edge
// Notes: data line idles at the inverse of the last bit
`timescale 1ns/1ps
module bit_source (
  input wire logic ref_clk,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic [7:0] signal_strength_value
);
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    signal_strength_value = 8'h00;
  end
  // send n bits, first bit is the most significant
  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      rx_bit_valid <= 1'b1;
      rx_bit <= w[i];
    end
    @(posedge ref_clk);
    rx_bit_valid <= 1'b0;
    rx_bit <= ~w[0];
  endtask
  // new measurement, 0.5 dB per step
  task automatic strength(input logic [7:0] v);
    @(posedge ref_clk);
    signal_strength_value <= v;
  endtask
endmodule // bit_source

// ===== verif/testbench.sv
// Purpose: self-checking bench for the receiver config block
// Assumes: zero wait state apb, byte address is index times four
// Notes: register model in an int array
`timescale 1ns/1ps
bind rx_sync_rssi_config rx_cfg_sva sva_i (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_bit_valid(rx_bit_valid), .signal_strength_value(signal_strength_value),
  .poly_centre_freq_sel(poly_centre_freq_sel), .poly_filter_on(poly_filter_on),
  .bit_synchronizer_on(bit_synchronizer_on), .pattern_match(pattern_match));
module testbench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rxv, rxb, filt, bsync, match;
  logic [7:0] sv;
  logic [3:0] freq;
  int mismatches = 0;
  int cmp_count = 0;
  int mdl [int];
  always #5 ref_clk = ~ref_clk;
  rx_sync_rssi_config dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(rxv), .rx_bit(rxb), .signal_strength_value(sv), .poly_centre_freq_sel(freq),
    .poly_filter_on(filt), .bit_synchronizer_on(bsync), .pattern_match(match));
  bit_source src (.ref_clk(ref_clk), .rx_bit_valid(rxv), .rx_bit(rxb), .signal_strength_value(sv));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial begin
    logic [31:0] p;
    logic [7:0] v;
    int n;
    void'($urandom(75335));
    mdl[rx_cfg_pkg::idx_poly_cfg] = rx_cfg_pkg::rst_poly_cfg;
    mdl[rx_cfg_pkg::idx_sync_ctl] = rx_cfg_pkg::rst_sync_ctl;
    mdl[rx_cfg_pkg::idx_spare] = rx_cfg_pkg::rst_spare;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values of registers and outputs
    foreach (mdl[i]) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", rd, mdl[i]);
    end
    chk("freq reset", freq, 4'h3);
    chk("filter reset", filt, 1'b0);
    chk("bitsync reset", bsync, 1'b1);
    // random writes, reserved bits kept as software must
    repeat (6) for (int i = 8'h11; i <= 8'h12; i++) begin
      v = $urandom;
      mdl[i] = (i == 8'h11) ? {v[7:4], 4'h8} : {v[7:1], 1'b0};
      apb(1'b1, 12'(i * 4), mdl[i]);
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("readback", rd, mdl[i]);
      chk("freq", freq, mdl[8'h11] >> 4);
      chk("filter", filt, mdl[8'h12] >> 7);
      chk("bitsync", bsync, !mdl[8'h12][6]);
    end
    $display("test registers done");
    // strength follows the live value, writes ignored
    repeat (3) begin
      v = $urandom;
      src.strength(v);
      apb(1'b1, 12'h050, {24'h0, ~v});
      apb(1'b0, 12'h050, 32'h0);
      chk("strength", rd, {24'h0, v});
    end
    $display("test strength done");
    apb(1'b0, 12'h3c0, 32'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h045, 32'hff);
    chk("misaligned err", er, 1'b1);
    $display("test refusals done");
    // every length, tolerance and enable, at and past the tolerance
    p = $urandom;
    for (int k = 0; k < 4; k++) apb(1'b1, 12'(12'h058 + 4 * k), {24'h0, p[31 - 8 * k -: 8]});
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, 12'h048, {24'h0, 2'b00, c[4], c[3:2], c[1:0], 1'b0});
      n = 8 * (c[3:2] + 1);
      for (int e = c % 4; e <= c % 4 + 1; e++) begin
        src.send((p >> (32 - n)) ^ ((32'h1 << e) - 1), n);
        #1;
        chk("match", match, c[4] && e <= c % 4);
      end
    end
    // last setting matched once, so the sticky flag is set; writing 1 clears it
    apb(1'b0, 12'h07c, 32'h0);
    chk("match seen", rd, 32'h1);
    apb(1'b1, 12'h07c, 32'h1);
    apb(1'b0, 12'h07c, 32'h0);
    chk("match cleared", rd, 32'h0);
    $display("test pattern done");
    complete_run();
  end
endmodule // testbench
